// ---- design/hpps_map.vh ----
// Register offsets, field positions, reset values and timing counts of the headphone sequencer
`ifndef HPPS_MAP_VH
`define HPPS_MAP_VH

// Register indices; the byte address of each is four times its index
`define HPPS_IDX_PWR_MGMT_ONE    7'h01
`define HPPS_IDX_CP_CTRL         7'h4C
`define HPPS_IDX_HP_ANALOGUE     7'h60
// Byte addresses on the 9-bit register bus
`define HPPS_ADDR_PWR_MGMT_ONE   {`HPPS_IDX_PWR_MGMT_ONE, 2'h0}
`define HPPS_ADDR_CP_CTRL        {`HPPS_IDX_CP_CTRL, 2'h0}
`define HPPS_ADDR_HP_ANALOGUE    {`HPPS_IDX_HP_ANALOGUE, 2'h0}
`define HPPS_ADDR_HP_VOLUME      9'h084
`define HPPS_ADDR_STATUS         9'h088
`define HPPS_ADDR_OSC_CTRL       9'h08C

// Field positions
`define HPPS_BIT_L_INPUT         9
`define HPPS_BIT_R_INPUT         8
`define HPPS_BIT_L_SHORT_REL     7
`define HPPS_BIT_L_OUTPUT        6
`define HPPS_BIT_L_INTERMED      5
`define HPPS_BIT_R_SHORT_REL     3
`define HPPS_BIT_R_OUTPUT        2
`define HPPS_BIT_R_INTERMED      1
`define HPPS_BIT_CP_EN           15
`define HPPS_BIT_OSC_EN          0

// Writable masks of the three 16-bit control registers
`define HPPS_MASK_PWR_MGMT_ONE   16'h0300
`define HPPS_MASK_CP_CTRL        16'h8000
`define HPPS_MASK_HP_ANALOGUE    16'h00EE

// Reset values
`define HPPS_RST_REG16           16'h0000
`define HPPS_RST_VOL             6'h00

// Volume field width and pump mode threshold
`define HPPS_VOL_W               6
`define HPPS_VOL_HIGH_THRESH     6'h30

// Charge pump clock divider (half period in system clocks)
`define HPPS_CP_DIV_HALF         4'h4

// Least wait from input stage to intermediate stage
`define HPPS_INTERMED_WAIT_NS    20000
`define HPPS_CLK_PERIOD_NS       100

`endif

// ---- design/hpps_sequencer.v ----
// Headphone pop-free power sequencer register block with APB slave
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "hpps_map.vh"

//------------------------------------------------------------
// Operation
//------------------------------------------------------------
// Operation
// RULE1: Output pins stay shorted to ground until their short-release bit is set.
// RULE2: Software enables input stages, then intermediate, then offset fix, then outputs.
// RULE3: Software disables short, intermediate and output bits before input stages.
// RULE4: Software runs offset correction between intermediate and output stages.
// RULE5: Power register holds left input stage at bit 9, right at 8.
// RULE6: Analogue register holds short-release bits at 7 and 3, reset applied.
// RULE7: Analogue register holds output-stage enables at bits 6 and 2.
// RULE8: Analogue register holds intermediate-stage enables at bits 5 and 1.
// RULE9: Software waits 20 us between input and intermediate stage enable.
// RULE10: Charge pump runs only while bit 15 of its control register is set.
// RULE11: Pump mode follows left and right volume settings automatically.
// RULE12: Pump clock divides system clock, only while oscillator is enabled.
// RULE13: Offset correction completion is reported per channel.
// RULE14: Controller waits for completion before output and short-release bits; this block does not gate them on i_dcs_complete.
module hpps_sequencer (
  input  wire        i_core_clk,
  input  wire        i_rst_b,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [8:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  input  wire [1:0]  i_dcs_complete,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  output reg         o_hp_left_input_stage_en,
  output reg         o_hp_right_input_stage_en,
  output reg         o_hp_left_intermediate_en,
  output reg         o_hp_right_intermediate_en,
  output reg         o_hp_left_output_stage_en,
  output reg         o_hp_right_output_stage_en,
  output reg         o_hp_left_pin_short,
  output reg         o_hp_right_pin_short,
  output reg         o_charge_pump_en,
  output reg         o_pump_high_mode,
  output reg         o_pump_clk
);

  //------------------------------------------------------------
  // Timing constants
  //------------------------------------------------------------
  // Least time rounds up; informative status only, software owns the wait
  // At the 100 ns core clock the wait is 200 cycles, inside the 8-bit timer
  localparam integer INTERMED_WAIT_CYC =
    (`HPPS_INTERMED_WAIT_NS + `HPPS_CLK_PERIOD_NS - 1) / `HPPS_CLK_PERIOD_NS;
  localparam [7:0] INTERMED_WAIT = INTERMED_WAIT_CYC[7:0];

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  // Software-visible state
  reg  [15:0]              pwr_mgmt_one_r;
  reg  [15:0]              cp_ctrl_r;
  reg  [15:0]              hp_analogue_r;
  reg  [`HPPS_VOL_W-1:0]   hp_left_volume_r;
  reg  [`HPPS_VOL_W-1:0]   hp_right_volume_r;
  reg                      oscillator_en_r;

  // Timers
  reg  [7:0]               settle_cnt_r;
  reg  [3:0]               cp_div_r;

  // Bus decode
  reg  [31:0]              rdata_nxt;
  reg                      hit_nxt;
  wire                     acc;
  wire                     wr;
  wire                     settled;

  // An access is taken once: pready high blocks a second take
  assign acc     = i_psel && i_penable && !o_pready;
  assign wr      = acc && i_pwrite;
  assign settled = (settle_cnt_r == INTERMED_WAIT);

  //------------------------------------------------------------
  // Read decode
  //------------------------------------------------------------
  // Unmapped addresses answer zero with pslverr
  // Status bits are live levels; nothing latches, software polls them
  always @* begin
    rdata_nxt = 32'h0000_0000;
    hit_nxt   = 1'b1;
    case (i_paddr)
      `HPPS_ADDR_PWR_MGMT_ONE: rdata_nxt = {16'h0000, pwr_mgmt_one_r};
      `HPPS_ADDR_CP_CTRL:      rdata_nxt = {16'h0000, cp_ctrl_r};
      `HPPS_ADDR_HP_ANALOGUE:  rdata_nxt = {16'h0000, hp_analogue_r};
      `HPPS_ADDR_HP_VOLUME:    rdata_nxt = {18'h00000, hp_left_volume_r, 2'h0,
                                            hp_right_volume_r};
      `HPPS_ADDR_STATUS:       rdata_nxt = {28'h0000000, settled, o_pump_high_mode,
                                            i_dcs_complete}; // RULE13
      `HPPS_ADDR_OSC_CTRL:     rdata_nxt = {31'h00000000, oscillator_en_r};
      default:                 hit_nxt   = 1'b0;
    endcase
  end

  //------------------------------------------------------------
  // APB slave: one wait state, answer in second access cycle
  //------------------------------------------------------------
  // pready, pslverr and prdata stand for one cycle only
  // Unmapped addresses still answer, so a bad access cannot hang the bus
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= acc;
      o_pslverr <= acc && !hit_nxt;
      o_prdata  <= (acc && !i_pwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

  //------------------------------------------------------------
  // Register writes, taken with the access that is answered
  //------------------------------------------------------------
  // Writes land on the same edge that raises pready, while the request still stands
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      pwr_mgmt_one_r    <= `HPPS_RST_REG16; // RULE5
      cp_ctrl_r         <= `HPPS_RST_REG16; // RULE10
      hp_analogue_r     <= `HPPS_RST_REG16; // RULE6
      hp_left_volume_r  <= `HPPS_RST_VOL;
      hp_right_volume_r <= `HPPS_RST_VOL;
      oscillator_en_r   <= 1'b0;
    end else if (wr) begin
      case (i_paddr)
        `HPPS_ADDR_PWR_MGMT_ONE: pwr_mgmt_one_r <= i_pwdata[15:0] & `HPPS_MASK_PWR_MGMT_ONE;
        `HPPS_ADDR_CP_CTRL:      cp_ctrl_r      <= i_pwdata[15:0] & `HPPS_MASK_CP_CTRL;
        `HPPS_ADDR_HP_ANALOGUE:  hp_analogue_r  <= i_pwdata[15:0] & `HPPS_MASK_HP_ANALOGUE;
        `HPPS_ADDR_HP_VOLUME: begin
          hp_right_volume_r <= i_pwdata[`HPPS_VOL_W-1:0];
          hp_left_volume_r  <= i_pwdata[`HPPS_VOL_W+7:8];
        end
        `HPPS_ADDR_OSC_CTRL:     oscillator_en_r <= i_pwdata[0];
        // Status is read-only; a write there is dropped without error
        `HPPS_ADDR_STATUS:       ;
        default: ;
      endcase
    end
  end

  //------------------------------------------------------------
  // Stage enables and ground shorts
  //------------------------------------------------------------
  // Order is left to software; the block just mirrors the bits
  // Reset shorts both pins so a half-powered driver never reaches the jack
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_hp_left_input_stage_en   <= 1'b0;
      o_hp_right_input_stage_en  <= 1'b0;
      o_hp_left_intermediate_en  <= 1'b0;
      o_hp_right_intermediate_en <= 1'b0;
      o_hp_left_output_stage_en  <= 1'b0;
      o_hp_right_output_stage_en <= 1'b0;
      o_hp_left_pin_short        <= 1'b1;
      o_hp_right_pin_short       <= 1'b1;
    end else begin
      o_hp_left_input_stage_en   <= pwr_mgmt_one_r[`HPPS_BIT_L_INPUT]; // RULE5
      o_hp_right_input_stage_en  <= pwr_mgmt_one_r[`HPPS_BIT_R_INPUT]; // RULE5
      o_hp_left_intermediate_en  <= hp_analogue_r[`HPPS_BIT_L_INTERMED]; // RULE8
      o_hp_right_intermediate_en <= hp_analogue_r[`HPPS_BIT_R_INTERMED]; // RULE8
      o_hp_left_output_stage_en  <= hp_analogue_r[`HPPS_BIT_L_OUTPUT]; // RULE7
      o_hp_right_output_stage_en <= hp_analogue_r[`HPPS_BIT_R_OUTPUT]; // RULE7
      o_hp_left_pin_short        <= !hp_analogue_r[`HPPS_BIT_L_SHORT_REL]; // RULE1
      o_hp_right_pin_short       <= !hp_analogue_r[`HPPS_BIT_R_SHORT_REL]; // RULE1
    end
  end

  //------------------------------------------------------------
  // Input stage settle timer, reported in status
  //------------------------------------------------------------
  // Counts while both input stages are on; saturates at the wait
  // Dropping either stage restarts the wait from zero
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      settle_cnt_r <= 8'h00;
    end else if (!(o_hp_left_input_stage_en && o_hp_right_input_stage_en)) begin
      settle_cnt_r <= 8'h00;
    end else if (!settled) begin
      settle_cnt_r <= settle_cnt_r + 8'h01; // RULE9
    end
  end

  //------------------------------------------------------------
  // Charge pump enable, mode and clock
  //------------------------------------------------------------
  // High rail mode when either channel is loud; no software mode bit
  // Mode trails the volume registers by one edge, like every other output
  // A restarted pump clock begins with a full low phase, never a runt
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_charge_pump_en <= 1'b0;
      o_pump_high_mode <= 1'b0;
      o_pump_clk       <= 1'b0;
      cp_div_r         <= 4'h0;
    end else begin
      o_charge_pump_en <= cp_ctrl_r[`HPPS_BIT_CP_EN]; // RULE10
      o_pump_high_mode <= (hp_left_volume_r >= `HPPS_VOL_HIGH_THRESH) ||
                          (hp_right_volume_r >= `HPPS_VOL_HIGH_THRESH); // RULE11
      // Pump clock stops low when the oscillator or the pump is off
      if (!(oscillator_en_r && cp_ctrl_r[`HPPS_BIT_CP_EN])) begin
        o_pump_clk <= 1'b0;
        cp_div_r   <= 4'h0;
      end else if (cp_div_r == `HPPS_CP_DIV_HALF - 4'h1) begin
        o_pump_clk <= !o_pump_clk; // RULE12
        cp_div_r   <= 4'h0;
      end else begin
        cp_div_r   <= cp_div_r + 4'h1;
      end
    end
  end

endmodule

// ---- bench/hpps_sequencer_asserts.sv ----
// Port-level checker of the headphone sequencer register block
`timescale 1ns/100ps
`include "hpps_map.vh"
module hpps_sequencer_asserts (
  input wire        i_core_clk,
  input wire        i_rst_b,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [8:0]  i_paddr,
  input wire [31:0] i_pwdata,
  input wire        o_pready,
  input wire        o_hp_left_input_stage_en,
  input wire        o_hp_right_input_stage_en,
  input wire        o_hp_left_intermediate_en,
  input wire        o_hp_right_intermediate_en,
  input wire        o_hp_left_output_stage_en,
  input wire        o_hp_right_output_stage_en,
  input wire        o_hp_left_pin_short,
  input wire        o_hp_right_pin_short,
  input wire        o_charge_pump_en,
  input wire        o_pump_high_mode,
  input wire        o_pump_clk
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // ------------------------------------------------------------
  // Write capture
  // ------------------------------------------------------------
  // Data kept from the take edge; the next take is at least three edges away
  reg  [15:0] wd_r;
  wire        wr_take = i_psel & i_penable & i_pwrite & ~o_pready;
  wire        to_pwr  = wr_take & (i_paddr == `HPPS_ADDR_PWR_MGMT_ONE);
  wire        to_ana  = wr_take & (i_paddr == `HPPS_ADDR_HP_ANALOGUE);
  wire        to_cp   = wr_take & (i_paddr == `HPPS_ADDR_CP_CTRL);
  wire        to_vol  = wr_take & (i_paddr == `HPPS_ADDR_HP_VOLUME);
  always @(posedge i_core_clk) begin
    if (wr_take)
      wd_r <= i_pwdata[15:0];
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_input;
    to_pwr |-> ##2 {o_hp_left_input_stage_en, o_hp_right_input_stage_en} == wd_r[9:8];
  endproperty
  a_input: assert property (p_input) else $error("input stage enable wrong");
  property p_stages;
    to_ana |-> ##2 {o_hp_left_output_stage_en, o_hp_left_intermediate_en,
                    o_hp_right_output_stage_en, o_hp_right_intermediate_en}
                   == {wd_r[6:5], wd_r[2:1]};
  endproperty
  a_stages: assert property (p_stages) else $error("stage enable wrong");
  property p_short;
    to_ana |-> ##2 {o_hp_left_pin_short, o_hp_right_pin_short} == ~{wd_r[7], wd_r[3]};
  endproperty
  a_short: assert property (p_short) else $error("pin short wrong");
  property p_reset_short;
    $rose(i_rst_b) |-> o_hp_left_pin_short && o_hp_right_pin_short;
  endproperty
  a_reset_short: assert property (p_reset_short)
    else $error("pins not shorted after reset");
  property p_pump_en; to_cp |-> ##2 o_charge_pump_en == wd_r[15]; endproperty
  a_pump_en: assert property (p_pump_en) else $error("pump enable wrong");
  property p_pump_off; !o_charge_pump_en [*2] |-> !o_pump_clk; endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump clock while disabled");
  property p_pump_low; $fell(o_pump_clk) |-> !o_pump_clk [*4]; endproperty
  a_pump_low: assert property (p_pump_low) else $error("pump clock low phase short");
  property p_mode;
    to_vol |-> ##2 o_pump_high_mode == (wd_r[13:8] >= 6'h30 || wd_r[5:0] >= 6'h30);
  endproperty
  a_mode: assert property (p_mode) else $error("pump mode wrong");
endmodule
bind hpps_sequencer hpps_sequencer_asserts i_chk (.*);

// ---- bench/hpps_sequencer_tb_top.sv ----
// Self-checking bench of the headphone sequencer register block
`timescale 1ns/100ps
`include "hpps_map.vh"
module hpps_sequencer_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [8:0]  paddr = 9'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [1:0]  dcs = 2'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  outs;
  logic        pump_clk;
  logic [15:0] pwr_m = 16'h0000;
  logic [15:0] ana_m = 16'h0000;
  logic [15:0] cp_m = 16'h0000;
  logic        hm_m = 1'b0;
  logic [31:0] rdv;
  logic        err;
  int          bits[6] = '{1, 2, 3, 5, 6, 7};
  logic [15:0] vols[3] = '{16'h2F2F, 16'h0030, 16'h3000};
  int          num_errors = 0;
  int          n_compared = 0;
  int          cnt;
  always #50 clk = ~clk;
  hpps_sequencer i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_dcs_complete(dcs),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_hp_left_input_stage_en(outs[9]), .o_hp_right_input_stage_en(outs[8]),
    .o_hp_left_intermediate_en(outs[7]), .o_hp_right_intermediate_en(outs[6]),
    .o_hp_left_output_stage_en(outs[5]), .o_hp_right_output_stage_en(outs[4]),
    .o_hp_left_pin_short(outs[3]), .o_hp_right_pin_short(outs[2]),
    .o_charge_pump_en(outs[1]), .o_pump_high_mode(outs[0]), .o_pump_clk(pump_clk));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the bounded wait keeps a dead slave from hanging the run
  task automatic apb(input logic wr, input logic [8:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // A spent wait counts as a mismatch and ends the run
    if (n >= 20) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(rdv, exp);
  endtask
  // Stage outputs trail the register by an edge, so look half a cycle later
  task automatic chk_outs;
    @(negedge clk);
    chk({22'h0, outs}, {22'h0, pwr_m[9:8], ana_m[5], ana_m[1], ana_m[6], ana_m[2],
        ~ana_m[7], ~ana_m[3], cp_m[15], hm_m});
  endtask
  task automatic count_high(input int n);
    cnt = 0;
    repeat (n) begin
      @(negedge clk);
      cnt += pump_clk;
    end
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(`HPPS_ADDR_PWR_MGMT_ONE, 32'h0);
    rd(`HPPS_ADDR_CP_CTRL, 32'h0);
    rd(`HPPS_ADDR_HP_ANALOGUE, 32'h0);
    chk_outs();
    $display("test reset done");
    // Enable in order, offset correction between middle and final step
    pwr_m = 16'h0300;
    apb(1'b1, `HPPS_ADDR_PWR_MGMT_ONE, pwr_m);
    chk_outs();
    repeat (200) @(posedge clk);
    rd(`HPPS_ADDR_STATUS, 32'h8);
    ana_m = 16'h0022;
    apb(1'b1, `HPPS_ADDR_HP_ANALOGUE, ana_m);
    chk_outs();
    // Both channels report completion before the output step
    @(posedge clk);
    dcs <= 2'h3;
    rd(`HPPS_ADDR_STATUS, 32'hB);
    ana_m = 16'h00EE;
    apb(1'b1, `HPPS_ADDR_HP_ANALOGUE, ana_m);
    chk_outs();
    apb(1'b1, `HPPS_ADDR_HP_ANALOGUE, 16'hFFFF);
    rd(`HPPS_ADDR_HP_ANALOGUE, 32'hEE);
    // Disable: output side first, input stages last
    ana_m = 16'h0000;
    apb(1'b1, `HPPS_ADDR_HP_ANALOGUE, ana_m);
    chk_outs();
    pwr_m = 16'h0000;
    apb(1'b1, `HPPS_ADDR_PWR_MGMT_ONE, pwr_m);
    chk_outs();
    $display("test sequence done");
    // Each analogue bit alone reaches only its own output
    foreach (bits[i]) begin
      ana_m = 16'h0001 << bits[i];
      apb(1'b1, `HPPS_ADDR_HP_ANALOGUE, ana_m);
      chk_outs();
    end
    $display("test bits done");
    // Pump clock runs at one eighth of the system clock only while enabled
    cp_m = 16'h8000;
    apb(1'b1, `HPPS_ADDR_CP_CTRL, cp_m);
    apb(1'b1, `HPPS_ADDR_OSC_CTRL, 16'h0001);
    chk_outs();
    count_high(80);
    chk(cnt, 32'h28);
    cp_m = 16'h0000;
    apb(1'b1, `HPPS_ADDR_CP_CTRL, cp_m);
    chk_outs();
    count_high(16);
    chk(cnt, 32'h0);
    for (int i = 0; i < 3; i++) begin
      hm_m = (i != 0);
      apb(1'b1, `HPPS_ADDR_HP_VOLUME, vols[i]);
      chk_outs();
    end
    $display("test pump done");
    // A second reset in mid-run clears every bit and shorts both pins again
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    ana_m = 16'h0000;
    hm_m  = 1'b0;
    chk_outs();
    rd(`HPPS_ADDR_HP_ANALOGUE, 32'h0);
    $display("test reset again done");
    apb(1'b1, 9'h0FC, 16'hFFFF);
    chk({31'h0, err}, 32'h1);
    rd(9'h0FC, 32'h0);
    chk({31'h0, err}, 32'h1);
    rd(`HPPS_ADDR_PWR_MGMT_ONE, 32'h0);
    $display("test unmapped done");
    wrap_up();
  end
endmodule
